/* File: verilog/rgi_target.sv */
// Overview of operation
// - answer only address 1110000; bit 8 gives direction; write form E0.
// - clock pin is input only; data pin only pulled low for reads and acks.
// - addresses, indexes and data move most significant bit first.
// - data changes while clock low; receiver samples on rising clock.
// - falling data with clock high starts a transaction, resets framing.
// - rising data with clock high ends it; target idles, releases data.
// - read sends index, repeated start, address again; target follows.
// - master code 00001xxx after start arms high speed; never acked.
// - repeated start after master code switches target into high speed.
// - high speed lasts until stop; packets separated by repeated starts.
// - target acks each accepted byte by pulling data low on ninth clock.
// - protocol identical at standard, fast, fast plus and high speed rates.
// - writing 1 to bit 0 of index 00 restores every register default.
// - index 01 holds output level; index 02 holds pass-through and mode.
`include "rgi_regs.svh"

module rgi_target
    import rgi_pkg::*;
#(
    parameter logic [7:0] VOUT_DEFAULT = `RGI_VOUT_DEFAULT,
    parameter logic [7:0] CTRL_DEFAULT = `RGI_CTRL_DEFAULT,
    parameter logic [7:0] MFR_ID       = `RGI_MFR_ID,
    parameter logic [7:0] DEV_ID       = `RGI_DEV_ID,
    parameter int         FIFO_DEPTH   = `RGI_FIFO_DEPTH
) (
    // system clock and reset
    input  wire logic       clk,
    input  wire logic       rst,
    // serial link: clock pin and open-drain data pin
    input  wire logic       scl,
    input  wire logic       sda_in,
    output logic            sda_out,
    output logic            sda_oe_n,
    // regulator controls and high-speed status
    output logic [7:0]      vout_ref,
    output logic            pass_through_control,
    output logic            forced_pwm,
    output logic            hs_mode
);
    localparam int BB_AW = `RGI_BIT_BUF_AW;

    function automatic logic [BB_AW:0] bin2gray(input logic [BB_AW:0] b);
        bin2gray = b ^ (b >> 1);
    endfunction

    // link side: bits sampled on the rising clock edge, gray write pointer
    logic [(1<<BB_AW)-1:0] bit_buf_reg;
    logic [BB_AW:0]        lw_ptr_reg;
    logic [BB_AW:0]        lw_gray_reg;

    // clock domain side
    logic [BB_AW:0]        lw_gray_s1_reg;
    logic [BB_AW:0]        lw_gray_s2_reg;
    logic [BB_AW:0]        rd_ptr_reg;
    logic                  scl_s1_reg;
    logic                  scl_s2_reg;
    logic                  scl_s3_reg;
    logic                  sda_s1_reg;
    logic                  sda_s2_reg;
    logic                  sda_s3_reg;
    rgi_state_t            state_reg;
    logic [3:0]            bit_cnt_reg;
    logic [7:0]            shift_reg;
    logic [7:0]            index_reg;
    logic [7:0]            wdata_reg;
    logic [7:0]            tx_reg;
    logic                  rd_mode_reg;
    logic                  mack_reg;
    logic                  hs_pend_reg;
    logic                  hs_mode_reg;
    logic                  sda_oe_n_reg;
    logic                  sda_out_reg;
    logic                  push_reg;
    rgi_wr_t               push_data_reg;
    logic [7:0]            vout_reg;
    logic [7:0]            ctrl_reg;

    logic                  bit_ev;
    logic                  bit_val;
    logic                  fall_ev;
    logic                  start_ev;
    logic                  stop_ev;
    logic                  byte_done;
    logic                  addr_hit;
    logic                  mcode_hit;
    logic [7:0]            rd_byte;
    rgi_wr_t               pop_word;
    logic                  pop;

    rgi_stream_if #(.WIDTH(16)) wr_s ();
    rgi_stream_if #(.WIDTH(16)) ap_s ();

    // bit capture runs on the link clock so the sample point is the edge
    always_ff @(posedge scl) begin
        bit_buf_reg[lw_ptr_reg[BB_AW-1:0]] <= sda_in;
    end

    // link pointer; link clock may stop, so reset is the system reset
    always_ff @(posedge scl or posedge rst) begin
        if (rst) begin
            lw_ptr_reg  <= '0;
            lw_gray_reg <= '0;
        end else begin
            lw_ptr_reg  <= lw_ptr_reg + 1'b1;
            lw_gray_reg <= bin2gray(lw_ptr_reg + 1'b1);
        end
    end

    // two-flop synchronisers for pointer and both pins
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            lw_gray_s1_reg <= '0;
            lw_gray_s2_reg <= '0;
            scl_s1_reg     <= 1'b1;
            scl_s2_reg     <= 1'b1;
            scl_s3_reg     <= 1'b1;
            sda_s1_reg     <= 1'b1;
            sda_s2_reg     <= 1'b1;
            sda_s3_reg     <= 1'b1;
        end else begin
            lw_gray_s1_reg <= lw_gray_reg;
            lw_gray_s2_reg <= lw_gray_s1_reg;
            scl_s1_reg     <= scl;
            scl_s2_reg     <= scl_s1_reg;
            scl_s3_reg     <= scl_s2_reg;
            sda_s1_reg     <= sda_in;
            sda_s2_reg     <= sda_s1_reg;
            sda_s3_reg     <= sda_s2_reg;
        end
    end

    // buffer entry is stable by the time its pointer shows up here
    assign bit_ev   = lw_gray_s2_reg != bin2gray(rd_ptr_reg);
    assign bit_val  = bit_buf_reg[rd_ptr_reg[BB_AW-1:0]];
    assign fall_ev  = scl_s3_reg && !scl_s2_reg;
    assign start_ev = scl_s2_reg && scl_s3_reg && sda_s3_reg && !sda_s2_reg;
    assign stop_ev  = scl_s2_reg && scl_s3_reg && !sda_s3_reg && sda_s2_reg;
    assign byte_done = fall_ev && (bit_cnt_reg == `RGI_BYTE_BITS);
    assign addr_hit  = shift_reg[7:1] == `RGI_TARGET_ADDR;
    assign mcode_hit = shift_reg[7:3] == `RGI_MCODE_TOP;

    // one bit consumed per cycle; link bits are far slower than clk
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            rd_ptr_reg <= '0;
        end else if (bit_ev) begin
            rd_ptr_reg <= rd_ptr_reg + 1'b1;
        end
    end

    // readback mux; index 00 reads zero as its bit clears itself
    always_comb begin
        case (index_reg)
            `RGI_IDX_VOUT:   rd_byte = vout_reg;
            `RGI_IDX_CTRL:   rd_byte = ctrl_reg;
            `RGI_IDX_MFR_ID: rd_byte = MFR_ID;
            `RGI_IDX_DEV_ID: rd_byte = DEV_ID;
            default:         rd_byte = 8'h00;
        endcase
    end

    // framing: start and repeated start restart at the address byte
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            state_reg   <= ST_IDLE;
            bit_cnt_reg <= 4'h0;
            shift_reg   <= 8'h00;
            index_reg   <= 8'h00;
            wdata_reg   <= 8'h00;
            rd_mode_reg <= 1'b0;
            mack_reg    <= 1'b1;
        end else if (start_ev) begin
            state_reg   <= ST_ADDR;
            bit_cnt_reg <= 4'h0;
        end else if (stop_ev) begin
            state_reg   <= ST_IDLE;
            bit_cnt_reg <= 4'h0;
        end else begin
            if (bit_ev) begin
                shift_reg <= {shift_reg[6:0], bit_val};
                if (bit_cnt_reg != 4'hf) begin
                    bit_cnt_reg <= bit_cnt_reg + 4'h1;
                end
            end
            case (state_reg)
                ST_ADDR: begin
                    if (byte_done) begin
                        rd_mode_reg <= shift_reg[0];
                        // master code and foreign addresses go unanswered
                        if (addr_hit && !mcode_hit) begin
                            state_reg <= ST_ADDR_ACK;
                        end else begin
                            state_reg <= ST_IGNORE;
                        end
                    end
                end
                ST_ADDR_ACK: begin
                    if (fall_ev) begin
                        state_reg   <= rd_mode_reg ? ST_RDATA : ST_INDEX;
                        bit_cnt_reg <= 4'h0;
                    end
                end
                ST_INDEX: begin
                    if (byte_done) begin
                        index_reg <= shift_reg;
                        state_reg <= ST_INDEX_ACK;
                    end
                end
                ST_INDEX_ACK: begin
                    if (fall_ev) begin
                        state_reg   <= ST_WDATA;
                        bit_cnt_reg <= 4'h0;
                    end
                end
                ST_WDATA: begin
                    if (byte_done) begin
                        wdata_reg <= shift_reg;
                        state_reg <= wr_s.ready ? ST_WDATA_ACK : ST_IGNORE;
                    end
                end
                ST_WDATA_ACK: begin
                    // one data byte per write; further bytes are refused
                    if (fall_ev) begin
                        state_reg <= ST_IGNORE;
                    end
                end
                ST_RDATA: begin
                    if (byte_done) begin
                        state_reg <= ST_RDATA_ACK;
                    end
                end
                ST_RDATA_ACK: begin
                    if (bit_ev) begin
                        mack_reg <= bit_val;
                    end
                    if (fall_ev) begin
                        state_reg   <= mack_reg ? ST_IGNORE : ST_RDATA;
                        bit_cnt_reg <= 4'h0;
                    end
                end
                ST_IDLE, ST_IGNORE: begin
                    state_reg <= state_reg;
                end
                default: state_reg <= ST_IDLE;
            endcase
        end
    end

    // data pin driver: changes follow a falling clock edge, except the release at start or stop
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            sda_oe_n_reg <= 1'b1;
            sda_out_reg  <= 1'b0;
            tx_reg       <= 8'h00;
        end else if (start_ev || stop_ev) begin
            sda_oe_n_reg <= 1'b1;
        end else if (fall_ev) begin
            case (state_reg)
                ST_ADDR:  sda_oe_n_reg <= !(byte_done && addr_hit);
                ST_INDEX: sda_oe_n_reg <= !byte_done;
                ST_WDATA: sda_oe_n_reg <= !(byte_done && wr_s.ready);
                ST_ADDR_ACK, ST_RDATA_ACK: begin
                    if ((state_reg == ST_ADDR_ACK && rd_mode_reg)
                        || (state_reg == ST_RDATA_ACK && !mack_reg)) begin
                        sda_oe_n_reg <= rd_byte[7];
                        tx_reg       <= {rd_byte[6:0], 1'b0};
                    end else begin
                        sda_oe_n_reg <= 1'b1;
                    end
                end
                ST_RDATA: begin
                    // release after the eighth bit so the master can answer
                    if (byte_done) begin
                        sda_oe_n_reg <= 1'b1;
                    end else begin
                        sda_oe_n_reg <= tx_reg[7];
                        tx_reg       <= {tx_reg[6:0], 1'b0};
                    end
                end
                default: sda_oe_n_reg <= 1'b1;
            endcase
        end
    end

    // high speed: armed by the master code, taken at the repeated start
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            hs_pend_reg <= 1'b0;
            hs_mode_reg <= 1'b0;
        end else if (stop_ev) begin
            hs_pend_reg <= 1'b0;
            hs_mode_reg <= 1'b0;
        end else if (start_ev) begin
            hs_pend_reg <= 1'b0;
            hs_mode_reg <= hs_mode_reg || hs_pend_reg;
        end else if (state_reg == ST_ADDR && byte_done && mcode_hit) begin
            hs_pend_reg <= 1'b1;
        end
    end

    // accepted write enters the fifo once its ack clock has ended
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            push_reg      <= 1'b0;
            push_data_reg <= '0;
        end else begin
            push_reg <= (state_reg == ST_WDATA_ACK) && fall_ev && !start_ev
                     && !stop_ev;
            push_data_reg <= '{index: index_reg, data: wdata_reg};
        end
    end

    assign wr_s.valid = push_reg;
    assign wr_s.data  = push_data_reg;

    rgi_fifo #(
        .WIDTH (16),
        .DEPTH (FIFO_DEPTH)
    ) u_fifo (
        .clk   (clk),
        .rst   (rst),
        .in_s  (wr_s),
        .out_s (ap_s)
    );

    // hold register contents steady while a byte is being shifted out
    assign ap_s.ready = state_reg != ST_RDATA;
    assign pop        = ap_s.valid && ap_s.ready;
    assign pop_word   = ap_s.data;

    // register file, updated from the fifo
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            vout_reg <= VOUT_DEFAULT;
            ctrl_reg <= CTRL_DEFAULT;
        end else if (pop) begin
            case (pop_word.index)
                `RGI_IDX_RESET: begin
                    if (pop_word.data[`RGI_SOFT_RESET_BIT]) begin
                        vout_reg <= VOUT_DEFAULT;
                        ctrl_reg <= CTRL_DEFAULT;
                    end
                end
                `RGI_IDX_VOUT: vout_reg <= pop_word.data;
                `RGI_IDX_CTRL: ctrl_reg <= pop_word.data;
                default:       vout_reg <= vout_reg;
            endcase
        end
    end

    assign sda_out              = sda_out_reg;
    assign sda_oe_n             = sda_oe_n_reg;
    assign vout_ref             = vout_reg;
    assign pass_through_control = ctrl_reg[`RGI_CTRL_PT_BIT];
    assign forced_pwm           = ctrl_reg[`RGI_CTRL_MODE_BIT];
    assign hs_mode              = hs_mode_reg;

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (rst);

    a_addr_ack_match: assert property (
        state_reg == ST_ADDR && byte_done && !start_ev && !stop_ev
        |=> sda_oe_n_reg == !$past(addr_hit))
        else $error("address byte answered wrongly");

    a_pin_pull_only: assert property (
        !sda_oe_n_reg |-> !sda_out_reg && state_reg inside
        {ST_ADDR_ACK, ST_INDEX_ACK, ST_WDATA_ACK, ST_RDATA})
        else $error("data pin driven outside ack or read data");

    a_change_low: assert property (
        $changed(sda_oe_n_reg) && !$past(start_ev) && !$past(stop_ev)
        |-> !$past(scl_s2_reg))
        else $error("data pin changed while clock high");

    a_start_reframe: assert property (
        start_ev |=> state_reg == ST_ADDR && bit_cnt_reg == 4'h0
        && sda_oe_n_reg)
        else $error("start did not reset framing");

    a_stop_idle: assert property (
        stop_ev |=> state_reg == ST_IDLE && sda_oe_n_reg && !hs_mode_reg)
        else $error("stop did not idle and release");

    a_mcode_nack: assert property (
        state_reg == ST_ADDR && byte_done && mcode_hit && !start_ev
        && !stop_ev |=> sda_oe_n_reg && hs_pend_reg ##1 sda_oe_n_reg)
        else $error("master code acknowledged or not armed");

    a_hs_enter: assert property (
        hs_pend_reg && start_ev |=> hs_mode_reg)
        else $error("repeated start did not enter high speed");

    a_hs_hold: assert property (
        hs_mode_reg && !stop_ev |=> hs_mode_reg)
        else $error("high speed left without stop");

    a_soft_reset: assert property (
        pop && pop_word.index == `RGI_IDX_RESET
        && pop_word.data[`RGI_SOFT_RESET_BIT]
        |=> vout_reg == VOUT_DEFAULT && ctrl_reg == CTRL_DEFAULT)
        else $error("soft reset missed a register");

    a_write_update: assert property (
        push_reg && wr_s.data[15:8] == `RGI_IDX_VOUT && ap_s.ready
        && !ap_s.valid |=> ##[0:2] vout_reg == $past(wr_s.data[7:0], 1))
        else $error("written level not applied");

    a_read_msb: assert property (
        state_reg == ST_ADDR_ACK && rd_mode_reg && fall_ev && !start_ev
        && !stop_ev |=> state_reg == ST_RDATA
        && sda_oe_n_reg == $past(rd_byte[7]))
        else $error("read byte not started with bit 7");

    c_write_pushed: cover property (push_reg && wr_s.ready);
    c_read_nacked: cover property (state_reg == ST_RDATA_ACK && fall_ev
        && mack_reg);
    c_hs_entered: cover property ($rose(hs_mode_reg));
    c_fifo_stall: cover property (ap_s.valid && !ap_s.ready);
endmodule

/* File: shared/rgi_regs.svh */
`ifndef RGI_REGS_SVH
`define RGI_REGS_SVH

// upper seven bits of the address byte that select this target
`define RGI_TARGET_ADDR    7'h70
// top five bits of the high-speed master code 00001xxx
`define RGI_MCODE_TOP      5'h01

// register indexes
`define RGI_IDX_RESET      8'h00
`define RGI_IDX_VOUT       8'h01
`define RGI_IDX_CTRL       8'h02
`define RGI_IDX_MFR_ID     8'h40
`define RGI_IDX_DEV_ID     8'h41

// field positions
`define RGI_SOFT_RESET_BIT 0
`define RGI_CTRL_PT_BIT    1
`define RGI_CTRL_MODE_BIT  0

// default values of the writable registers
`define RGI_VOUT_DEFAULT   8'h00
`define RGI_CTRL_DEFAULT   8'h00

// identity bytes, values are arbitrary
`define RGI_MFR_ID         8'h5a
`define RGI_DEV_ID         8'h01

// sizing and counts
`define RGI_FIFO_DEPTH     8
`define RGI_BIT_BUF_AW     2
`define RGI_BYTE_BITS      4'h8

`endif

/* File: shared/rgi_pkg.sv */
package rgi_pkg;

    // framing states of the serial target
    typedef enum logic [3:0] {
        ST_IDLE,
        ST_ADDR,
        ST_ADDR_ACK,
        ST_INDEX,
        ST_INDEX_ACK,
        ST_WDATA,
        ST_WDATA_ACK,
        ST_RDATA,
        ST_RDATA_ACK,
        ST_IGNORE
    } rgi_state_t;

    // one register write travelling through the fifo
    typedef struct packed {
        logic [7:0] index;
        logic [7:0] data;
    } rgi_wr_t;

endpackage

/* File: shared/rgi_stream_if.sv */
interface rgi_stream_if #(
    parameter int WIDTH = 16
);
    logic             valid;
    logic             ready;
    logic [WIDTH-1:0] data;

    // producer side and consumer side
    modport tx (output valid, output data, input ready);
    modport rx (input valid, input data, output ready);
endinterface

/* File: verilog/rgi_fifo.sv */
`include "rgi_regs.svh"

module rgi_fifo #(
    parameter int WIDTH = 16,
    parameter int DEPTH = `RGI_FIFO_DEPTH
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // filling side
    rgi_stream_if.rx in_s,
    // draining side
    rgi_stream_if.tx out_s
);
    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem_reg [DEPTH];
    logic [AW:0]      wr_ptr_reg;
    logic [AW:0]      rd_ptr_reg;
    logic             full;
    logic             empty;
    logic             push;
    logic             pop;

    // extra pointer bit tells full from empty when the indexes meet
    assign empty = wr_ptr_reg == rd_ptr_reg;
    assign full  = (wr_ptr_reg[AW-1:0] == rd_ptr_reg[AW-1:0])
                && (wr_ptr_reg[AW] != rd_ptr_reg[AW]);
    assign push  = in_s.valid && !full;
    assign pop   = out_s.ready && !empty;

    assign in_s.ready  = !full;
    assign out_s.valid = !empty;
    assign out_s.data  = mem_reg[rd_ptr_reg[AW-1:0]];

    // storage needs no reset, only valid entries are ever read
    always_ff @(posedge clk) begin
        if (push) begin
            mem_reg[wr_ptr_reg[AW-1:0]] <= in_s.data;
        end
    end

    // write pointer
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            wr_ptr_reg <= '0;
        end else if (push) begin
            wr_ptr_reg <= wr_ptr_reg + 1'b1;
        end
    end

    // read pointer
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            rd_ptr_reg <= '0;
        end else if (pop) begin
            rd_ptr_reg <= rd_ptr_reg + 1'b1;
        end
    end
endmodule

/* File: tb/rgi_i2c_model.sv */
// bus master on the far side; the data wire has a pull-up, so released is 1
module rgi_i2c_model (
    // link pins driven by the master
    output logic      scl,
    output logic      sda_m,
    // resolved level of the data wire
    input  wire logic sda
);
    timeunit 1ns;
    timeprecision 100ps;

    // quarter of a bit time, set by the bench to pick the bus rate
    int q = 260;

    // both lines idle high, clock stands still between frames
    initial begin
        scl = 1'b1;
        sda_m = 1'b1;
    end

    // start or repeated start: data falls while clock is high
    task automatic start();
        sda_m = 1'b1;
        #q;
        scl = 1'b1;
        #q;
        sda_m = 1'b0;
        #q;
        scl = 1'b0;
    endtask

    // stop: data rises while clock is high, then both stay high
    task automatic stop();
        #q;
        sda_m = 1'b0;
        #q;
        scl = 1'b1;
        #q;
        sda_m = 1'b1;
        #q;
    endtask

    // one byte msb first plus the ninth clock; send ff to read
    task automatic xfer(input logic [7:0] tx, input logic ack_in,
                        output logic [7:0] rx, output logic ack);
        for (int i = 7; i >= 0; i--) begin
            #q;
            sda_m = tx[i];
            #q;
            scl = 1'b1;
            #q;
            rx[i] = sda;
            #q;
            scl = 1'b0;
        end
        #q;
        sda_m = ack_in;
        #q;
        scl = 1'b1;
        #q;
        ack = sda;
        #q;
        scl = 1'b0;
    endtask
endmodule

/* File: tb/testbench.sv */
module testbench;
    timeunit 1ns;
    timeprecision 100ps;

    logic       clk = 1'b0;
    logic       rst = 1'b1;
    logic       scl;
    logic       sda_m;
    wire        sda;
    logic       sda_out;
    logic       sda_oe_n;
    logic [7:0] vout_ref;
    logic       pass_through_control;
    logic       forced_pwm;
    logic       hs_mode;
    int         n_mismatch = 0;
    int         comparisons = 0;

    always #2 clk = ~clk;

    rgi_target u_dut (.clk(clk), .rst(rst), .scl(scl), .sda_in(sda),
        .sda_out(sda_out), .sda_oe_n(sda_oe_n), .vout_ref(vout_ref),
        .pass_through_control(pass_through_control),
        .forced_pwm(forced_pwm), .hs_mode(hs_mode));
    rgi_i2c_model u_m (.scl(scl), .sda_m(sda_m), .sda(sda));

    // open-drain wire: low if either party pulls, else the pull-up wins
    assign sda = sda_m & (sda_oe_n | sda_out);

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        comparisons++;
        if (got !== exp) begin
            n_mismatch++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // a driven data pin may only ever pull low
    always @(negedge clk) begin
        if (sda_oe_n === 1'b0) chk({7'h00, sda_out}, 8'h00);
    end

    // register write; the leading start doubles as a repeated start
    task automatic wr(input logic [7:0] a, input logic [7:0] idx,
                      input logic [7:0] d, input logic fin,
                      output logic [7:0] nk);
        logic [7:0] r;
        nk = 8'h00;
        u_m.start();
        u_m.xfer(a, 1'b1, r, nk[2]);
        u_m.xfer(idx, 1'b1, r, nk[1]);
        u_m.xfer(d, 1'b1, r, nk[0]);
        if (fin) u_m.stop();
    endtask

    // register read ending with a master not-acknowledge
    task automatic rd(input logic [7:0] idx, output logic [7:0] d,
                      output logic [7:0] nk);
        logic [7:0] r;
        logic       na;
        nk = 8'h00;
        u_m.start();
        u_m.xfer(8'he0, 1'b1, r, nk[2]);
        u_m.xfer(idx, 1'b1, r, nk[1]);
        u_m.start();
        u_m.xfer(8'he1, 1'b1, r, nk[0]);
        u_m.xfer(8'hff, 1'b1, d, na);
        u_m.stop();
    endtask

    task automatic t_reset();
        chk(vout_ref, 8'h00);
        chk({sda_oe_n, pass_through_control, forced_pwm, hs_mode}, 8'h08);
        $display("reset test done");
    endtask

    // asymmetric bit pattern exposes a reversed shift order
    task automatic t_write();
        logic [7:0] nk;
        wr(8'he0, 8'h01, 8'hc2, 1'b1, nk);
        chk(nk, 8'h00);
        chk(vout_ref, 8'hc2);
        wr(8'he0, 8'h02, 8'h02, 1'b1, nk);
        chk({pass_through_control, forced_pwm}, 8'h02);
        chk({7'h00, sda_oe_n}, 8'h01);
        $display("write test done");
    endtask

    task automatic t_read();
        logic [7:0] d;
        logic [7:0] nk;
        rd(8'h01, d, nk);
        chk(d, 8'hc2);
        chk(nk, 8'h00);
        rd(8'h41, d, nk);
        chk(d, 8'h01);
        $display("read test done");
    endtask

    // another target's address gets no acknowledge and changes nothing
    task automatic t_foreign();
        logic [7:0] nk;
        wr(8'he2, 8'h01, 8'h00, 1'b1, nk);
        chk(nk, 8'h07);
        chk(vout_ref, 8'hc2);
        $display("address test done");
    endtask

    // master code below 1 MHz, then packets at about 3.3 MHz
    task automatic t_hs();
        logic [7:0] r;
        logic [7:0] nk;
        logic       na;
        u_m.start();
        u_m.xfer(8'h0d, 1'b1, r, na);
        chk({7'h00, na}, 8'h01);
        u_m.q = 75;
        wr(8'he0, 8'h01, 8'h3c, 1'b0, nk);
        chk({7'h00, hs_mode}, 8'h01);
        chk(nk, 8'h00);
        rd(8'h01, r, nk);
        chk(r, 8'h3c);
        chk({7'h00, hs_mode}, 8'h00);
        u_m.q = 260;
        $display("high speed test done");
    endtask

    task automatic t_soft();
        logic [7:0] nk;
        wr(8'he0, 8'h00, 8'h01, 1'b1, nk);
        chk(vout_ref, 8'h00);
        chk({pass_through_control, forced_pwm}, 8'h00);
        $display("soft reset test done");
    endtask

    task automatic stop_test();
        $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
        if (n_mismatch == 0 && comparisons > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    // the tests need about 230 us
    initial begin
        #400000;
        n_mismatch++;
        stop_test();
    end

    initial begin
        repeat (10) @(negedge clk);
        rst = 1'b0;
        repeat (4) @(negedge clk);
        t_reset();
        t_write();
        t_read();
        t_foreign();
        t_hs();
        t_soft();
        stop_test();
    end
endmodule
